// ==== bench/ofad_cpu_model.sv ====
// CPU bus master model that issues one access at a time to the decoder.
`timescale 1ns/1ns
`default_nettype none
module ofad_cpu_model
(
	input wire logic clk_in,
	input wire logic ack_in,
	input wire logic stall_in,
	output logic req_out,
	output logic [23:0] addr_out,
	output logic write_out,
	output logic byte_out
);
	int stall_cnt = 0;
	initial
	begin
		req_out = 1'b0;
		addr_out = 24'h000000;
		write_out = 1'b0;
		byte_out = 1'b0;
	end
	// The request stays up through stalls and drops once its ack shows.
	task automatic access(input logic [23:0] a, input logic w, input logic b);
		@(negedge clk_in);
		addr_out = a;
		write_out = w;
		byte_out = b;
		req_out = 1'b1;
		do
		begin
			@(negedge clk_in);
			if (stall_in === 1'b1)
				stall_cnt++;
		end
		while (ack_in !== 1'b1);
		req_out = 1'b0;
		addr_out = ~a;
	endtask
endmodule
`default_nettype wire

// ==== bench/ofad_decoder_tb.sv ====
// Self-checking testbench for the flash address decoder.
`timescale 1ns/1ns
`default_nettype none
module ofad_decoder_tb;
	import ofad_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, boot = 1'b0, ack, stall, d_byte, d_wr;
	logic req, wr, bt, ext, dmx, prog, refd, ext_lat = 1'b0;
	logic [23:0] addr, laddr;
	logic [15:0] sys_cfg = SYSCFG_RESET, xper = XPER_RESET;
	logic [1:0] wait_in = WS_ZERO, bank, ws;
	logic [3:0] op_start = 4'h0, op_done = 4'h0, busy;
	logic [2:0] tgt;
	int err_total = 0, cmp_count = 0, ref_cnt = 0, cyc = 0;
	always #20 clk = ~clk;
	ofad_decoder u_ofad_decoder (.clk_in(clk), .rstn_in(rstn), .req_in(req),
		.addr_in(addr), .write_in(wr), .byte_in(bt), .boot_mode_in(boot),
		.system_config_reg_in(sys_cfg), .ext_periph_enable_reg_in(xper),
		.extension_flash_wait_in(wait_in), .op_start_in(op_start),
		.op_done_in(op_done), .ack_out(ack), .stall_out(stall),
		.target_out(tgt), .bank_out(bank), .local_addr_out(laddr),
		.byte_out(d_byte), .write_out(d_wr), .ext_bus_req_out(ext),
		.demux16_out(dmx), .wait_states_out(ws), .prog_allowed_out(prog),
		.op_refused_out(refd), .bank_busy_out(busy));
	ofad_cpu_model u_ofad_cpu_model (.clk_in(clk), .ack_in(ack),
		.stall_in(stall), .req_out(req), .addr_out(addr), .write_out(wr),
		.byte_out(bt));
	always @(posedge clk)
	begin
		if (ack === 1'b1)
			ext_lat <= ext;
		if (refd === 1'b1)
			ref_cnt++;
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			finish_test();
		end
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [23:0] a, input logic b,
		input logic [2:0] t, input logic [1:0] bk);
		u_ofad_cpu_model.access(a, 1'b0, b);
		@(posedge clk);
		#1;
		chk(tgt, t);
		chk(laddr, a);
		chk(d_byte, b);
		chk(d_wr, 1'b0);
		chk(ext_lat, t == 3'h5);
		chk(dmx, t == 3'h3 || t == 3'h4);
		if (t < 3'h4)
			chk(bank, bk);
		@(negedge clk);
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		chk(tgt, 3'h0);
		chk(ack, 1'b0);
		rstn = 1'b1;
		acc(24'h000100, 1'b0, 3'h1, BANK_0);
		acc(24'h07fffe, 1'b1, 3'h1, BANK_1);
		boot = 1'b1;
		acc(24'h001ffe, 1'b0, 3'h2, BANK_0);
		acc(24'h002000, 1'b0, 3'h1, BANK_0);
		boot = 1'b0;
		for (int e = 0; e < 4; e++)
		begin
			sys_cfg[SYSCFG_EXT_PERIPH_GLOBAL_ENABLE_BIT] = e[1];
			xper[XPER_XFEN_BIT] = e[0];
			acc(24'h0a0010, 1'b1, (e == 3) ? 3'h3 : 3'h5, BANK_2);
		end
		for (int i = 0; i < 6; i++)
			acc(24'(24'h090000 + i * 24'h010000), 1'b0,
				(i == 5) ? 3'h4 : 3'h3,
				(i < 3) ? BANK_2 : BANK_3);
		// Software picks one wait state only above the threshold clock.
		wait_in = (CPU_MHZ > WS_THRESH_MHZ) ? WS_ONE : WS_ZERO;
		acc(24'h0c0000, 1'b0, 3'h3, BANK_3);
		chk(ws, WS_ZERO);
		wait_in = WS_ONE;
		acc(24'h090000, 1'b0, 3'h3, BANK_2);
		chk(ws, WS_ONE);
		acc(24'h0d0000, 1'b0, 3'h3, BANK_3);
		wait_in = WS_ZERO;
		op_start = 4'h4;
		@(negedge clk);
		op_start = 4'h0;
		@(negedge clk);
		chk(busy, 4'h4);
		chk(prog, 1'b1);
		fork
			acc(24'h0b0000, 1'b0, 3'h3, BANK_2);
			begin
				repeat (4) @(negedge clk);
				op_done = 4'h4;
				@(negedge clk);
				op_done = 4'h0;
			end
		join
		chk(u_ofad_cpu_model.stall_cnt != 0, 1'b1);
		chk(busy, 4'h0);
		sys_cfg[SYSCFG_EXT_PERIPH_GLOBAL_ENABLE_BIT] = 1'b0;
		@(negedge clk);
		op_start = 4'h8;
		@(negedge clk);
		op_start = 4'h0;
		repeat (2) @(negedge clk);
		chk(prog, 1'b0);
		chk(ref_cnt, 1);
		chk(busy, 4'h0);
		finish_test();
	end
endmodule
`default_nettype wire

// ==== verilog/ofad_bank_busy.sv ====
// Per-bank busy tracker that records program and erase activity.
`timescale 1ns/1ns
`default_nettype none
module ofad_bank_busy
	import ofad_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] op_start_in,
	input wire logic [3:0] op_done_in,
	output logic [3:0] busy_out
);
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_bank
			// A start in the same cycle as a done keeps the bank busy.
			always_ff @(posedge clk_in or negedge rstn_in)
			begin
				if (!rstn_in)
					busy_out[g] <= 1'b0;
				else if (op_start_in[g])
					busy_out[g] <= 1'b1;
				else if (op_done_in[g])
					busy_out[g] <= 1'b0;
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ==== verilog/ofad_decoder.sv ====
// Address decoder for main flash, extension flash and flash control window.
//
// Behaviour
// RQ1 - The decoder covers a linear 16 Mbyte space with byte and word accesses.
// RQ2 - The main flash is 512 Kbytes, bank 0 below and bank 1 above.
// RQ3 - A read of a bank is held off while a program or erase runs in it.
// RQ4 - In bootstrap mode the 8 Kbyte boot test block sits at address zero.
// RQ5 - The extension window hits extension flash only with both enables set.
// RQ6 - With the global enable clear the window goes to the external bus.
// RQ7 - Extension flash is three 64 Kbyte blocks in bank 2, two in bank 3.
// RQ8 - The flash control registers take the 64 Kbyte window above them.
// RQ9 - Program and erase are refused when the control window is closed; the code refuses them in banks 2 and 3 only.
// RQ10 - Extension flash is reached as a 16-bit demultiplexed bus, no delay.
// RQ11 - Software sets one wait state above 40 MHz, none otherwise.
// RQ12 - Extension flash takes byte and word accesses.
// RQ13 - With global enable set but flash enable clear, go to external bus.
`timescale 1ns/1ns
`default_nettype none
module ofad_decoder
	import ofad_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic req_in,
	input wire logic [23:0] addr_in,
	input wire logic write_in,
	input wire logic byte_in,
	input wire logic boot_mode_in,
	input wire logic [15:0] system_config_reg_in,
	input wire logic [15:0] ext_periph_enable_reg_in,
	input wire logic [1:0] extension_flash_wait_in,
	input wire logic [3:0] op_start_in,
	input wire logic [3:0] op_done_in,
	output logic ack_out,
	output logic stall_out,
	output logic [2:0] target_out,
	output logic [1:0] bank_out,
	output logic [23:0] local_addr_out,
	output logic byte_out,
	output logic write_out,
	output logic ext_bus_req_out,
	output logic demux16_out,
	output logic [1:0] wait_states_out,
	output logic prog_allowed_out,
	output logic op_refused_out,
	output logic [3:0] bank_busy_out
);
	logic ext_periph_global_enable;
	logic ext_flash_enable;
	logic fctrl_open;
	logic [7:0] seg;
	logic in_xwin;
	logic [3:0] busy;
	logic [3:0] start_ok;
	ofad_target_t tgt_next;
	logic [1:0] bank_next;
	logic read_blocked;
	logic [1:0] wait_cnt_reg;
	logic wait_active_reg;

	assign ext_periph_global_enable = system_config_reg_in[SYSCFG_EXT_PERIPH_GLOBAL_ENABLE_BIT];
	assign ext_flash_enable = ext_periph_enable_reg_in[XPER_XFEN_BIT];
	assign seg = addr_in[SEG_HI:SEG_LO];
	assign in_xwin = (seg >= SEG_XF_FIRST) && (seg <= SEG_FCTRL);
	// The control window opens under the same enables as the array.
	assign fctrl_open = ext_periph_global_enable && ext_flash_enable; // see RQ9
	// Extension bank operations need the control window to be reachable.
	assign start_ok = {fctrl_open, fctrl_open, 2'b11} & op_start_in; // see RQ9

	ofad_bank_busy u_busy (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.op_start_in(start_ok),
		.op_done_in(op_done_in),
		.busy_out(busy)
	);

	// Target and bank selection for the current request.
	always_comb
	begin
		tgt_next = OFAD_T_EXT;
		bank_next = BANK_0;
		if (boot_mode_in && (addr_in < BOOT_LIMIT))
			tgt_next = OFAD_T_BOOT; // see RQ4
		else if (addr_in < MF_LIMIT)
		begin
			tgt_next = OFAD_T_MAIN; // see RQ2
			bank_next = (addr_in >= MF_BANK1_BASE) ? BANK_1 : BANK_0;
		end
		else if (in_xwin)
		begin
			if (!ext_periph_global_enable)
				tgt_next = OFAD_T_EXT; // see RQ6
			else if (!ext_flash_enable)
				tgt_next = OFAD_T_EXT; // see RQ13
			else if (seg == SEG_FCTRL)
				tgt_next = OFAD_T_FCTRL; // see RQ8
			else
			begin
				tgt_next = OFAD_T_EXTENSION_FLASH; // see RQ5
				bank_next = (seg <= SEG_B2_LAST) ? BANK_2 : BANK_3; // see RQ7
			end
		end
	end

	// Reads of a busy flash bank wait until the operation ends.
	assign read_blocked = req_in && !write_in && busy[bank_next] &&
		((tgt_next == OFAD_T_MAIN) || (tgt_next == OFAD_T_EXTENSION_FLASH)); // see RQ3

	// Wait states counted only for extension flash accesses.
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wait_cnt_reg <= WS_ZERO;
			wait_active_reg <= 1'b0;
		end
		else if (wait_active_reg)
		begin
			if (wait_cnt_reg == WS_ZERO)
				wait_active_reg <= 1'b0;
			else
				wait_cnt_reg <= wait_cnt_reg - WS_ONE;
		end
		else if (req_in && !read_blocked && tgt_next == OFAD_T_EXTENSION_FLASH &&
			extension_flash_wait_in != WS_ZERO)
		begin
			wait_active_reg <= 1'b1;
			wait_cnt_reg <= extension_flash_wait_in - WS_ONE; // see RQ11
		end
	end

	// Decoded request outputs, one registered answer per accepted request.
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			ack_out <= 1'b0;
			stall_out <= 1'b0;
			target_out <= OFAD_T_NONE;
			bank_out <= BANK_0;
			local_addr_out <= '0;
			byte_out <= 1'b0;
			write_out <= 1'b0;
			ext_bus_req_out <= 1'b0;
			demux16_out <= 1'b0;
		end
		else
		begin
			stall_out <= read_blocked;
			ack_out <= 1'b0;
			ext_bus_req_out <= 1'b0;
			if (req_in && !read_blocked && !wait_active_reg)
			begin
				// Full 24-bit address, any byte or word. see RQ1
				ack_out <= 1'b1;
				target_out <= tgt_next;
				bank_out <= bank_next;
				local_addr_out <= addr_in;
				byte_out <= byte_in; // see RQ12
				write_out <= write_in;
				ext_bus_req_out <= (tgt_next == OFAD_T_EXT); // see RQ6
				// Extension flash is a 16-bit demux bus without delay. see RQ10
				demux16_out <= (tgt_next == OFAD_T_EXTENSION_FLASH) ||
					(tgt_next == OFAD_T_FCTRL);
			end
		end
	end

	// Status outputs.
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wait_states_out <= WS_ZERO;
			prog_allowed_out <= 1'b0;
			op_refused_out <= 1'b0;
			bank_busy_out <= 4'h0;
		end
		else
		begin
			wait_states_out <= extension_flash_wait_in;
			prog_allowed_out <= fctrl_open; // see RQ9
			op_refused_out <= |(op_start_in & ~start_ok); // see RQ9
			bank_busy_out <= busy;
		end
	end

	chk_busy_read_stall: // see RQ3
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		read_blocked |=> stall_out && !ack_out)
	else $error("read of busy bank was not stalled");

	chk_xwin_ext_route: // see RQ6
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(req_in && in_xwin && !ext_periph_global_enable && !wait_active_reg)
		|=> ext_bus_req_out && target_out == OFAD_T_EXT)
	else $error("window not forwarded to external bus");

	chk_extension_flash_hit: // see RQ5
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ack_out && target_out == OFAD_T_EXTENSION_FLASH) |->
		$past(ext_periph_global_enable) && $past(ext_flash_enable))
	else $error("extension flash hit without both enables");

	chk_flash_off_ext: // see RQ13
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(req_in && in_xwin && ext_periph_global_enable && !ext_flash_enable
		&& !wait_active_reg) |=> ext_bus_req_out)
	else $error("disabled extension flash not routed out");

	chk_boot_block_map: // see RQ4
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(req_in && boot_mode_in && addr_in < BOOT_LIMIT && !wait_active_reg)
		|=> target_out == OFAD_T_BOOT)
	else $error("boot block not mapped at zero");

	chk_ctrl_window: // see RQ8
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ack_out && target_out == OFAD_T_FCTRL) |->
		local_addr_out[SEG_HI:SEG_LO] == SEG_FCTRL)
	else $error("control window decoded outside its segment");

	chk_extension_flash_bank: // see RQ7
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ack_out && target_out == OFAD_T_EXTENSION_FLASH) |->
		bank_out == ((local_addr_out[SEG_HI:SEG_LO] <= SEG_B2_LAST)
		? BANK_2 : BANK_3))
	else $error("extension flash bank wrong");

	chk_main_bank: // see RQ2
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ack_out && target_out == OFAD_T_MAIN) |->
		local_addr_out < MF_LIMIT &&
		(bank_out == BANK_1) == (local_addr_out >= MF_BANK1_BASE))
	else $error("main flash bank wrong");

	chk_prog_refused: // see RQ9
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(|op_start_in[BANK_3:BANK_2] && !fctrl_open) |=> op_refused_out)
	else $error("program started with control window closed");

	chk_demux_mode: // see RQ10
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ack_out && target_out == OFAD_T_EXTENSION_FLASH) |-> demux16_out)
	else $error("extension flash not in demux 16-bit mode");

	chk_byte_pass: // see RQ12
	assert property (@(posedge clk_in) disable iff (!rstn_in)
		(req_in && !read_blocked && !wait_active_reg) |=>
		byte_out == $past(byte_in))
	else $error("byte width not passed through");
endmodule
`default_nettype wire

// ==== verilog/ofad_pkg.sv ====
// Package with the address map and timing constants of the flash address decoder.
package ofad_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	// Segment field is address bits 23..16.
	localparam int SEG_HI = 23;
	localparam int SEG_LO = 16;
	localparam logic [7:0] SEG_XF_FIRST = 8'h09;
	localparam logic [7:0] SEG_XF_LAST = 8'h0d;
	localparam logic [7:0] SEG_FCTRL = 8'h0e;
	localparam logic [7:0] SEG_B2_LAST = 8'h0b;
	// Main flash: 512 Kbytes from address zero, bank 1 in the upper part.
	localparam logic [23:0] MF_LIMIT = 24'h080000;
	localparam logic [23:0] MF_BANK1_BASE = 24'h040000;
	// Boot test block: 8 Kbytes at the bottom while bootstrap is selected.
	localparam logic [23:0] BOOT_LIMIT = 24'h002000;
	localparam int SYSCFG_EXT_PERIPH_GLOBAL_ENABLE_BIT = 2;
	localparam int XPER_XFEN_BIT = 5;
	localparam logic [15:0] SYSCFG_RESET = 16'h0000;
	localparam logic [15:0] XPER_RESET = 16'h0000;
	localparam int BANK_W = 2;
	localparam logic [1:0] BANK_0 = 2'h0;
	localparam logic [1:0] BANK_1 = 2'h1;
	localparam logic [1:0] BANK_2 = 2'h2;
	localparam logic [1:0] BANK_3 = 2'h3;
	// Wait state threshold for software, in MHz; the clock runs at 25 MHz.
	localparam int CPU_MHZ = 25;
	localparam int WS_THRESH_MHZ = 40;
	localparam logic [1:0] WS_ZERO = 2'h0;
	localparam logic [1:0] WS_ONE = 2'h1;
	typedef enum logic [2:0] {
		OFAD_T_NONE,
		OFAD_T_MAIN,
		OFAD_T_BOOT,
		OFAD_T_EXTENSION_FLASH,
		OFAD_T_FCTRL,
		OFAD_T_EXT
	} ofad_target_t;
endpackage
